// ### core/eip_top.sv
// External interrupt pin controller with an AXI4-Lite register slave.
`timescale 1ns/100ps
`default_nettype none
module eip_top
  import eip_pkg::*;
(
  input  wire logic                CLK,           // system clock, 50 MHz
  input  wire logic                SYS_RST,       // synchronous reset, active high
  input  wire logic [ADDR_W-1:0]   S_AXI_AWADDR,  // write address
  input  wire logic                S_AXI_AWVALID, // write address valid
  output logic                     S_AXI_AWREADY, // write address ready
  input  wire logic [31:0]         S_AXI_WDATA,   // write data
  input  wire logic [3:0]          S_AXI_WSTRB,   // write byte strobes
  input  wire logic                S_AXI_WVALID,  // write data valid
  output logic                     S_AXI_WREADY,  // write data ready
  output logic [1:0]               S_AXI_BRESP,   // write response
  output logic                     S_AXI_BVALID,  // write response valid
  input  wire logic                S_AXI_BREADY,  // write response ready
  input  wire logic [ADDR_W-1:0]   S_AXI_ARADDR,  // read address
  input  wire logic                S_AXI_ARVALID, // read address valid
  output logic                     S_AXI_ARREADY, // read address ready
  output logic [31:0]              S_AXI_RDATA,   // read data
  output logic [1:0]               S_AXI_RRESP,   // read response
  output logic                     S_AXI_RVALID,  // read data valid
  input  wire logic                S_AXI_RREADY,  // read data ready
  input  wire logic [NUM_PINS-1:0] INT_PIN_IN,    // pin levels
  output wire logic [NUM_PINS-1:0] INT_PIN_OUT,   // pin drive levels
  output wire logic [NUM_PINS-1:0] INT_PIN_OE,    // pin drive enables
  input  wire logic [NUM_PINS-1:0] INT_ACK,       // request acknowledges
  output wire logic [NUM_PINS-1:0] REQ_PEND,      // pending requests
  output wire logic [NUM_PINS-1:0] REQ_NMI,       // pending request is nonmaskable
  output wire logic [NUM_PINS-1:0] REQ_LOW_PRI,   // pending request is low priority
  output wire logic [NUM_PINS-1:0] REQ_STROBE,    // one pulse per request
  output logic                     IRQ            // summary interrupt, level
);
  eip_wr_state_type wr_state_ff;
  logic              aw_hold_ff, w_hold_ff;
  logic [ADDR_W-1:0] awaddr_ff;
  logic [15:0]       wdata_ff;
  logic [1:0]        wstrb_ff;
  logic              do_write;
  logic [2:0]        wr_sel, rd_sel;
  logic [NUM_PINS-1:0] pol_ff, pri_ff, en_ff, nmi_ff, dir_ff, dout_ff;
  logic [NUM_PINS-1:0] flag_q, level_q, edge_q, nmi_rd;
  logic [NUM_PINS-1:0] evt_status_ff, evt_mask_ff;
  logic [15:0]       rd_word [NUM_PINS];
  logic [31:0]       rd_value;
  logic              bad_read;

  eip_chan_if ch_if [NUM_PINS] ();

  assign wr_sel = eip_decode(awaddr_ff);
  assign rd_sel = eip_decode(S_AXI_ARADDR);
  assign do_write = (wr_state_ff == WR_IDLE) && aw_hold_ff && w_hold_ff;

  // Address and data are taken in either order; the write happens once both are held.
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      S_AXI_AWREADY <= 1'b0;
      aw_hold_ff <= 1'b0;
      awaddr_ff <= '0;
    end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      S_AXI_AWREADY <= 1'b0;
      aw_hold_ff <= 1'b1;
      awaddr_ff <= S_AXI_AWADDR;
    end else if (S_AXI_BVALID && S_AXI_BREADY) begin
      aw_hold_ff <= 1'b0;
      S_AXI_AWREADY <= 1'b1;
    end else if (!aw_hold_ff) begin
      S_AXI_AWREADY <= 1'b1;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      S_AXI_WREADY <= 1'b0;
      w_hold_ff <= 1'b0;
      wdata_ff <= '0;
      wstrb_ff <= '0;
    end else if (S_AXI_WVALID && S_AXI_WREADY) begin
      S_AXI_WREADY <= 1'b0;
      w_hold_ff <= 1'b1;
      wdata_ff <= S_AXI_WDATA[15:0];
      wstrb_ff <= S_AXI_WSTRB[1:0];
    end else if (S_AXI_BVALID && S_AXI_BREADY) begin
      w_hold_ff <= 1'b0;
      S_AXI_WREADY <= 1'b1;
    end else if (!w_hold_ff) begin
      S_AXI_WREADY <= 1'b1;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      wr_state_ff <= WR_IDLE;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= RESP_OKAY;
    end else begin
      unique case (wr_state_ff)
        WR_IDLE: begin
          if (do_write) begin
            wr_state_ff <= WR_RESP;
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP <= (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
          end
        end
        WR_RESP: begin
          if (S_AXI_BREADY) begin
            wr_state_ff <= WR_IDLE;
            S_AXI_BVALID <= 1'b0;
          end
        end
      endcase
    end
  end

  // Control bits; a lane that is not strobed keeps its bits.
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      pol_ff <= {NUM_PINS{CFG_RST}};
      pri_ff <= {NUM_PINS{CFG_RST}};
      en_ff <= {NUM_PINS{CFG_RST}};
      nmi_ff <= {NUM_PINS{CFG_RST}};
      dir_ff <= {NUM_PINS{CFG_RST}};
      dout_ff <= {NUM_PINS{CFG_RST}};
    end else begin
      for (int i = 0; i < NUM_PINS; i++) begin
        if (do_write && wr_sel == 3'(i) && wstrb_ff[0]) begin
          pol_ff[i] <= wdata_ff[POL_BIT];
          pri_ff[i] <= wdata_ff[PRI_BIT];
          en_ff[i] <= wdata_ff[EN_BIT];
          if (i >= NUM_TYPE_A) begin
            nmi_ff[i] <= wdata_ff[NMI_BIT];
            dir_ff[i] <= wdata_ff[DIR_BIT];
            dout_ff[i] <= wdata_ff[DOUT_BIT];
          end
        end
      end
    end
  end

  // Event status: set by each detected edge, cleared by writing a one.
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      evt_status_ff <= EVT_RST;
      evt_mask_ff <= EVT_RST;
      IRQ <= 1'b0;
    end else begin
      if (do_write && wr_sel == SEL_STATUS && wstrb_ff[0]) begin
        evt_status_ff <= (evt_status_ff & ~wdata_ff[NUM_PINS-1:0]) | edge_q;
      end else begin
        evt_status_ff <= evt_status_ff | edge_q;
      end
      if (do_write && wr_sel == SEL_MASK && wstrb_ff[0]) begin
        evt_mask_ff <= wdata_ff[NUM_PINS-1:0];
      end
      IRQ <= |(evt_status_ff & evt_mask_ff);
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_PINS; g++) begin : g_pin
      localparam bit IS_B = (g >= NUM_TYPE_A);
      localparam bit NMI_HW = IS_B ? 1'b0 : TYPE_A_NMI_FIXED[g % NUM_TYPE_A];
      assign ch_if[g].pol = pol_ff[g];
      assign ch_if[g].pri = pri_ff[g];
      assign ch_if[g].en = en_ff[g];
      assign ch_if[g].nmi = nmi_ff[g];
      assign ch_if[g].dir = dir_ff[g];
      assign ch_if[g].dout = dout_ff[g];
      assign ch_if[g].ack = INT_ACK[g];
      assign ch_if[g].flag_clr = do_write && wr_sel == 3'(g) && wstrb_ff[1]
                                 && wdata_ff[FLAG_BIT];
      assign flag_q[g] = ch_if[g].flag;
      assign level_q[g] = ch_if[g].level;
      assign edge_q[g] = ch_if[g].edge_evt;
      assign nmi_rd[g] = IS_B ? nmi_ff[g] : NMI_HW;
      assign INT_PIN_OUT[g] = ch_if[g].pin_out;
      assign INT_PIN_OE[g] = ch_if[g].pin_oe;
      assign REQ_PEND[g] = ch_if[g].pend;
      assign REQ_NMI[g] = ch_if[g].req_nmi;
      assign REQ_LOW_PRI[g] = ch_if[g].req_lo;
      assign REQ_STROBE[g] = ch_if[g].req_evt;
      assign rd_word[g] = {flag_q[g], 8'h00, level_q[g], nmi_rd[g], dir_ff[g],
                           dout_ff[g], pol_ff[g], pri_ff[g], en_ff[g]};
      eip_pin_chan #(
        .IS_TYPE_B (IS_B),
        .NMI_FIXED (NMI_HW)
      ) u_chan (
        .clk    (CLK),
        .rst    (SYS_RST),
        .pin_in (INT_PIN_IN[g]),
        .ch     (ch_if[g])
      );
    end
  endgenerate

  always_comb begin
    rd_value = 32'h0;
    bad_read = 1'b0;
    unique case (rd_sel)
      3'h0: rd_value = {16'h0, rd_word[0]};
      3'h1: rd_value = {16'h0, rd_word[1]};
      3'h2: rd_value = {16'h0, rd_word[2]};
      3'h3: rd_value = {16'h0, rd_word[3]};
      SEL_STATUS: rd_value = {28'h0, evt_status_ff};
      SEL_MASK: rd_value = {28'h0, evt_mask_ff};
      default: bad_read = 1'b1;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0;
      S_AXI_RRESP <= RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA <= rd_value;
      S_AXI_RRESP <= bad_read ? RESP_SLVERR : RESP_OKAY;
    end else if (S_AXI_RVALID && S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_ARREADY <= 1'b1;
    end else if (!S_AXI_RVALID) begin
      S_AXI_ARREADY <= 1'b1;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  a_reset_inputs: assert property ($past(SYS_RST) |-> INT_PIN_OE == '0 && en_ff == '0
                                   && nmi_ff == '0)
    else $error("pins not inputs after reset");
  a_irq_follows: assert property (##1 IRQ == $past(|(evt_status_ff & evt_mask_ff)))
    else $error("irq does not follow status and mask");
  a_type_a_fixed: assert property (rd_word[0][NMI_BIT] == 1'b0 && rd_word[1][NMI_BIT] == 1'b1)
    else $error("hardwired nonmaskable bit wrong");
  a_reserved_zero: assert property (S_AXI_RVALID && S_AXI_RRESP == RESP_OKAY
                                    |-> S_AXI_RDATA[14:7] == 8'h00)
    else $error("reserved bits read nonzero");
  a_read_holds: assert property (S_AXI_RVALID && !S_AXI_RREADY
                                 |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read data dropped before taken");
  a_bad_write: assert property (do_write && wr_sel == SEL_NONE
                                |=> S_AXI_BVALID && S_AXI_BRESP == RESP_SLVERR)
    else $error("unmapped write not refused");
  a_flag_no_set: assert property ((flag_q & ~$past(flag_q) & ~edge_q) == '0)
    else $error("flag set without an edge");

  a_aw_busy: assert property (aw_hold_ff |-> !S_AXI_AWREADY)
    else $error("write address taken twice");
  a_w_busy: assert property (w_hold_ff |-> !S_AXI_WREADY)
    else $error("write data taken twice");
  a_aw_ready_idle: assert property (!aw_hold_ff ##1 !aw_hold_ff |-> S_AXI_AWREADY)
    else $error("idle write address not ready");
  a_w_ready_idle: assert property (!w_hold_ff ##1 !w_hold_ff |-> S_AXI_WREADY)
    else $error("idle write data not ready");
  a_write_answer: assert property (do_write |=> S_AXI_BVALID)
    else $error("write gave no response");
  a_resp_state: assert property (S_AXI_BVALID |-> wr_state_ff == WR_RESP)
    else $error("response outside response state");
  a_b_done: assert property (S_AXI_BVALID && S_AXI_BREADY
                             |=> !S_AXI_BVALID && S_AXI_AWREADY && S_AXI_WREADY)
    else $error("write channels not reopened");
  a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY
                                  |=> S_AXI_RVALID && !S_AXI_ARREADY)
    else $error("read gave no data");
  a_read_busy: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
    else $error("read address taken during data");
  a_ar_ready_idle: assert property (!S_AXI_RVALID ##1 !S_AXI_RVALID |-> S_AXI_ARREADY)
    else $error("idle read address not ready");
  a_r_done: assert property (S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID && S_AXI_ARREADY)
    else $error("read channel not reopened");
  a_rdata_upper: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:16] == 16'h0)
    else $error("upper read data nonzero");

  a_enabled_input: assert property ((INT_PIN_OE & $past(en_ff | nmi_ff)) == '0)
    else $error("interrupt pin driven as output");
  a_type_a_undriven: assert property (INT_PIN_OE[NUM_TYPE_A-1:0] == '0)
    else $error("input-only pin driven");
  a_type_a_rsvd: assert property (dir_ff[NUM_TYPE_A-1:0] == '0
                                  && dout_ff[NUM_TYPE_A-1:0] == '0)
    else $error("reserved bits of input-only pin stored");
  a_fixed_nmi_ro: assert property (nmi_ff[NUM_TYPE_A-1:0] == '0)
    else $error("hardwired nonmaskable bit stored");
  a_pol_written: assert property (do_write && wr_sel == 3'h2 && wstrb_ff[0]
                                  |=> pol_ff[2] == $past(wdata_ff[POL_BIT]))
    else $error("polarity write lost");
  a_nmi_written: assert property (do_write && wr_sel == 3'h3 && wstrb_ff[0]
                                  |=> nmi_ff[3] == $past(wdata_ff[NMI_BIT]))
    else $error("nonmaskable select write lost");

  a_strobe_single: assert property ((REQ_STROBE & $past(REQ_STROBE)) == '0)
    else $error("request strobe wider than one cycle");
  a_strobe_pends: assert property ((REQ_STROBE & ~REQ_PEND) == '0)
    else $error("strobe without pending request");
  a_request_gated: assert property ((REQ_STROBE & ~$past(en_ff | nmi_rd)) == '0)
    else $error("request from a disabled pin");
  a_nmi_not_low: assert property ((REQ_PEND & REQ_NMI & REQ_LOW_PRI) == '0)
    else $error("nonmaskable request marked low priority");
  a_type_a_kind: assert property (REQ_STROBE[1] |-> REQ_NMI[1] && !REQ_LOW_PRI[1])
    else $error("hardwired pin gave maskable request");

  a_status_source: assert property ((evt_status_ff & ~$past(evt_status_ff)
                                     & ~$past(edge_q)) == '0)
    else $error("event status set without an edge");
  a_status_clear: assert property (do_write && wr_sel == SEL_STATUS && wstrb_ff[0]
                                   |=> (evt_status_ff
                                        & $past(wdata_ff[NUM_PINS-1:0] & ~edge_q)) == '0)
    else $error("event status not cleared");
  a_mask_write: assert property (do_write && wr_sel == SEL_MASK && wstrb_ff[0]
                                 |=> evt_mask_ff == $past(wdata_ff[NUM_PINS-1:0]))
    else $error("event mask write lost");

  c_write_done: cover property (do_write ##[1:4] S_AXI_BVALID && S_AXI_BREADY);
  c_irq_raised: cover property ($rose(IRQ));
  c_read_done: cover property (S_AXI_RVALID && S_AXI_RREADY);
endmodule : eip_top
`default_nettype wire

// ### core/eip_pkg.sv
// Constants, register map and types for the external interrupt pin controller.
package eip_pkg;
  localparam int NUM_PINS = 4;
  localparam int NUM_TYPE_A = 2;
  localparam int ADDR_W = 8;
  localparam logic [1:0] TYPE_A_NMI_FIXED = 2'h2;
  localparam logic [ADDR_W-1:0] OFS_CTRL_A0 = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CTRL_A1 = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_CTRL_B0 = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_CTRL_B1 = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_EVT_STATUS = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_EVT_MASK = 8'h14;
  localparam int FLAG_BIT = 15;
  localparam int LEVEL_BIT = 6;
  localparam int NMI_BIT = 5;
  localparam int DIR_BIT = 4;
  localparam int DOUT_BIT = 3;
  localparam int POL_BIT = 2;
  localparam int PRI_BIT = 1;
  localparam int EN_BIT = 0;
  localparam logic CFG_RST = 1'b0;
  localparam logic [NUM_PINS-1:0] EVT_RST = 4'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [2:0] SEL_STATUS = 3'h4;
  localparam logic [2:0] SEL_MASK = 3'h5;
  localparam logic [2:0] SEL_NONE = 3'h7;

  typedef enum logic [0:0] {
    WR_IDLE = 1'b0,
    WR_RESP = 1'b1
  } eip_wr_state_type;

  // Maps a byte address to a pin index, status, mask or no register.
  function automatic logic [2:0] eip_decode(input logic [ADDR_W-1:0] addr);
    logic [2:0] sel;
    sel = SEL_NONE;
    unique case (addr)
      OFS_CTRL_A0: sel = 3'h0;
      OFS_CTRL_A1: sel = 3'h1;
      OFS_CTRL_B0: sel = 3'h2;
      OFS_CTRL_B1: sel = 3'h3;
      OFS_EVT_STATUS: sel = SEL_STATUS;
      OFS_EVT_MASK: sel = SEL_MASK;
      default: sel = SEL_NONE;
    endcase
    return sel;
  endfunction : eip_decode
endpackage : eip_pkg

// ### core/eip_chan_if.sv
// Configuration and status carried between the register file and one pin channel.
`timescale 1ns/100ps
`default_nettype none
interface eip_chan_if;
  logic pol, pri, en, nmi, dir, dout, flag_clr, ack;
  logic flag, level, pend, req_nmi, req_lo, req_evt, edge_evt, pin_out, pin_oe;
  modport ctrl (
    output pol, pri, en, nmi, dir, dout, flag_clr, ack,
    input  flag, level, pend, req_nmi, req_lo, req_evt, edge_evt, pin_out, pin_oe
  );
  modport chan (
    input  pol, pri, en, nmi, dir, dout, flag_clr, ack,
    output flag, level, pend, req_nmi, req_lo, req_evt, edge_evt, pin_out, pin_oe
  );
endinterface : eip_chan_if
`default_nettype wire

// ### core/eip_pin_chan.sv
// One interrupt pin: synchroniser, edge detector, flag, request and output drive.
`timescale 1ns/100ps
`default_nettype none
module eip_pin_chan
  import eip_pkg::*;
#(
  parameter bit IS_TYPE_B = 1'b0,
  parameter bit NMI_FIXED = 1'b0
) (
  input wire logic   clk,     // system clock
  input wire logic   rst,     // synchronous reset, active high
  input wire logic   pin_in,  // pin level from the pad
  eip_chan_if.chan   ch       // configuration and status
);
  logic sync1_ff, sync2_ff, prev_ff, flag_ff, pend_ff;
  logic req_nmi_ff, req_lo_ff, req_evt_ff, edge_evt_ff, pin_out_ff, pin_oe_ff;
  logic nmi_eff, want_req, hit;

  assign nmi_eff = IS_TYPE_B ? ch.nmi : NMI_FIXED;
  assign want_req = nmi_eff | ch.en;
  assign hit = ch.pol ? (sync2_ff & ~prev_ff) : (~sync2_ff & prev_ff);

  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
      prev_ff <= 1'b0;
    end else begin
      sync1_ff <= pin_in;
      sync2_ff <= sync1_ff;
      prev_ff <= sync2_ff;
    end
  end

  // A new edge in the clearing cycle keeps the flag set.
  always_ff @(posedge clk) begin
    if (rst) begin
      flag_ff <= CFG_RST;
    end else if (hit) begin
      flag_ff <= 1'b1;
    end else if (ch.flag_clr) begin
      flag_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pend_ff <= 1'b0;
      req_nmi_ff <= 1'b0;
      req_lo_ff <= 1'b0;
      req_evt_ff <= 1'b0;
      edge_evt_ff <= 1'b0;
    end else begin
      req_evt_ff <= hit & want_req;
      edge_evt_ff <= hit;
      if (hit && want_req) begin
        pend_ff <= 1'b1;
        req_nmi_ff <= nmi_eff;
        req_lo_ff <= ~nmi_eff & ch.pri;
      end else if (ch.flag_clr || ch.ack) begin
        pend_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pin_oe_ff <= 1'b0;
      pin_out_ff <= 1'b0;
    end else begin
      pin_oe_ff <= IS_TYPE_B & ch.dir & ~ch.en & ~ch.nmi;
      pin_out_ff <= IS_TYPE_B & ch.dout;
    end
  end

  assign ch.flag = flag_ff;
  assign ch.level = sync2_ff;
  assign ch.pend = pend_ff;
  assign ch.req_nmi = req_nmi_ff;
  assign ch.req_lo = req_lo_ff;
  assign ch.req_evt = req_evt_ff;
  assign ch.edge_evt = edge_evt_ff;
  assign ch.pin_out = pin_out_ff;
  assign ch.pin_oe = pin_oe_ff;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_flag_on_edge: assert property (hit |=> flag_ff)
    else $error("flag not set after edge");
  a_level_follow: assert property (##3 ch.level == $past(pin_in, 2))
    else $error("pin level bit lags wrong");
  a_clear_withdraws: assert property (ch.flag_clr && !hit |=> !pend_ff && !flag_ff)
    else $error("clear left request pending");
  a_req_each_edge: assert property (hit && want_req |=> req_evt_ff && pend_ff)
    else $error("edge gave no request");
  a_type_a_input: assert property (!IS_TYPE_B |-> !pin_oe_ff)
    else $error("input-only pin driven");
  a_nmi_ignores_pri: assert property (hit && nmi_eff |=> req_nmi_ff && !req_lo_ff)
    else $error("priority used for nonmaskable");
  c_two_edges: cover property (req_evt_ff ##[1:20] req_evt_ff && flag_ff);
  c_drive_out: cover property (pin_oe_ff && pin_out_ff);
endmodule : eip_pin_chan
`default_nettype wire

// ### bench/eip_pin_src.sv
// Model of the external sources that drive the interrupt pins.
`timescale 1ns/100ps
`default_nettype none
module eip_pin_src
  import eip_pkg::*;
(
  input  wire logic [NUM_PINS-1:0] drive_lvl, // level each source wants
  input  wire logic [NUM_PINS-1:0] pin_out,   // device drive level
  input  wire logic [NUM_PINS-1:0] pin_oe,    // device drive enable
  output wire logic [NUM_PINS-1:0] pin_lvl    // resolved wire level
);
  // A source yields its pin while the device drives it, so the wire shows the drive.
  assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & drive_lvl);
endmodule : eip_pin_src
`default_nettype wire

// ### bench/tb.sv
// Self-checking testbench for the external interrupt pin controller.
`timescale 1ns/100ps
`default_nettype none
module tb;
  import eip_pkg::*;
  localparam logic [31:0] B_FLAG = 32'h1 << FLAG_BIT;
  localparam logic [31:0] B_LVL  = 32'h1 << LEVEL_BIT;
  localparam logic [31:0] B_NMI  = 32'h1 << NMI_BIT;
  localparam logic [31:0] B_DIR  = 32'h1 << DIR_BIT;
  localparam logic [31:0] B_DOUT = 32'h1 << DOUT_BIT;
  localparam logic [31:0] B_POL  = 32'h1 << POL_BIT;
  localparam logic [31:0] B_PRI  = 32'h1 << PRI_BIT;
  localparam logic [31:0] B_EN   = 32'h1 << EN_BIT;
  logic                clk, sys_rst, awvalid, wvalid, bready, arvalid, rready;
  logic                awready, wready, bvalid, arready, rvalid, irq;
  logic [ADDR_W-1:0]   awaddr, araddr;
  logic [31:0]         wdata, rdata, rd_val;
  logic [3:0]          wstrb;
  logic [1:0]          bresp, rresp, resp;
  logic [NUM_PINS-1:0] drv, lvl, pout, poe, ack, pend, rnmi, rlow, strobe;
  int                  n_errors, samples_checked, s;
  int                  strobes [NUM_PINS] = '{default: 0};

  eip_top eip_top_i (.CLK(clk), .SYS_RST(sys_rst), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready), .INT_PIN_IN(lvl), .INT_PIN_OUT(pout), .INT_PIN_OE(poe),
    .INT_ACK(ack), .REQ_PEND(pend), .REQ_NMI(rnmi), .REQ_LOW_PRI(rlow),
    .REQ_STROBE(strobe), .IRQ(irq));
  eip_pin_src eip_pin_src_i (.drive_lvl(drv), .pin_out(pout), .pin_oe(poe), .pin_lvl(lvl));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk) begin
    for (int p = 0; p < NUM_PINS; p++) if (strobe[p] === 1'b1) strobes[p] <= strobes[p] + 1;
  end

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : chk

  task automatic give_up;
    n_errors++;
    $display("CHECK FAILED at %0t: bus answer never came", $time);
    tally_and_finish();
  endtask : give_up

  task automatic wait_cy(input int n);
    repeat (n) @(posedge clk);
  endtask : wait_cy

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int k;
    @(posedge clk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge clk);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    r = bresp;
    bready <= 1'b0;
    if (k == 50) give_up();
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int k;
    @(posedge clk);
    araddr <= a; arvalid <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge clk);
      if (rready && rvalid === 1'b1) break;
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      else if (!arvalid) rready <= 1'b1;
    end
    d = rdata; r = rresp;
    rready <= 1'b0;
    if (k == 50) give_up();
  endtask : axi_read

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    axi_write(a, d, resp);
    chk(resp, RESP_OKAY, "write response");
  endtask : reg_wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1);
    axi_read(a, rd_val, resp);
    chk(resp, RESP_OKAY, "read response");
    chk(rd_val & m, e, "register value");
  endtask : rd_chk

  task automatic set_pin(input int p, input logic v);
    @(posedge clk);
    drv[p] <= v;
    wait_cy(6);
  endtask : set_pin

  task automatic do_reset;
    @(posedge clk);
    sys_rst <= 1'b1;
    wait_cy(6);
    sys_rst <= 1'b0;
    wait_cy(2);
  endtask : do_reset

  task automatic t_reset;
    chk(poe, 4'h0, "pins leave reset as inputs");
    rd_chk(OFS_CTRL_A0, 32'h0);
    rd_chk(OFS_CTRL_A1, B_NMI);
    rd_chk(OFS_CTRL_B0, 32'h0);
    rd_chk(OFS_CTRL_B1, 32'h0);
    rd_chk(OFS_EVT_STATUS, 32'h0);
    rd_chk(OFS_EVT_MASK, 32'h0);
    reg_wr(OFS_CTRL_B1, 32'hffff7f80);
    rd_chk(OFS_CTRL_B1, 32'h0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_poll;
    reg_wr(OFS_CTRL_B0, B_POL);
    s = strobes[2];
    set_pin(2, 1'b1);
    rd_chk(OFS_CTRL_B0, B_FLAG | B_LVL | B_POL);
    chk(pend[2], 1'b0, "no request while disabled");
    chk(strobes[2] - s, 0, "no strobe while disabled");
    reg_wr(OFS_CTRL_B0, B_POL);
    rd_chk(OFS_CTRL_B0, B_FLAG, B_FLAG);
    reg_wr(OFS_CTRL_B0, B_FLAG | B_POL);
    rd_chk(OFS_CTRL_B0, 32'h0, B_FLAG);
    set_pin(2, 1'b0);
    rd_chk(OFS_CTRL_B0, B_POL);
    $display("test polling done");
  endtask : t_poll

  task automatic t_request;
    reg_wr(OFS_CTRL_A0, B_NMI | B_DIR | B_DOUT | B_PRI | B_EN);
    rd_chk(OFS_CTRL_A0, B_PRI | B_EN);
    chk(poe[0], 1'b0, "first type never drives");
    set_pin(0, 1'b1);
    s = strobes[0];
    set_pin(0, 1'b0);
    chk({pend[0], rnmi[0], rlow[0]}, 3'h5, "low priority request");
    set_pin(0, 1'b1);
    set_pin(0, 1'b0);
    chk(strobes[0] - s, 2, "one strobe per edge");
    reg_wr(OFS_CTRL_A0, B_FLAG | B_PRI | B_EN);
    wait_cy(2);
    chk(pend[0], 1'b0, "flag clear drops request");
    reg_wr(OFS_CTRL_A0, B_EN);
    set_pin(0, 1'b1);
    set_pin(0, 1'b0);
    chk({pend[0], rlow[0]}, 2'h2, "high priority request");
    @(posedge clk);
    ack[0] <= 1'b1;
    @(posedge clk);
    ack[0] <= 1'b0;
    wait_cy(2);
    chk(pend[0], 1'b0, "acknowledge drops request");
    $display("test request done");
  endtask : t_request

  task automatic t_nmi;
    reg_wr(OFS_CTRL_A1, B_POL | B_PRI);
    set_pin(1, 1'b1);
    chk({pend[1], rnmi[1], rlow[1]}, 3'h6, "hardwired nonmaskable");
    reg_wr(OFS_CTRL_B1, B_NMI | B_DIR | B_POL | B_PRI);
    rd_chk(OFS_CTRL_B1, B_NMI | B_DIR | B_POL | B_PRI);
    set_pin(3, 1'b1);
    chk({pend[3], rnmi[3], rlow[3]}, 3'h6, "programmed nonmaskable");
    $display("test nonmaskable done");
  endtask : t_nmi

  task automatic t_output;
    reg_wr(OFS_CTRL_B0, B_DIR | B_DOUT);
    wait_cy(4);
    chk({poe[2], pout[2]}, 2'h3, "drive high");
    rd_chk(OFS_CTRL_B0, B_LVL, B_LVL);
    reg_wr(OFS_CTRL_B0, B_DIR);
    wait_cy(4);
    chk({poe[2], pout[2]}, 2'h2, "drive low");
    reg_wr(OFS_CTRL_B0, B_DIR | B_DOUT | B_EN);
    wait_cy(2);
    chk(poe[2], 1'b0, "enabled pin is input");
    $display("test output done");
  endtask : t_output

  task automatic t_irq;
    reg_wr(OFS_EVT_STATUS, 32'hf);
    reg_wr(OFS_EVT_MASK, 32'h0);
    set_pin(3, 1'b0);
    set_pin(3, 1'b1);
    rd_chk(OFS_EVT_STATUS, 32'h8);
    chk(irq, 1'b0, "masked event");
    reg_wr(OFS_EVT_MASK, 32'h8);
    wait_cy(2);
    chk(irq, 1'b1, "unmasked event");
    reg_wr(OFS_EVT_STATUS, 32'h8);
    wait_cy(2);
    chk(irq, 1'b0, "event cleared");
    axi_write(8'h18, 32'hffff, resp);
    chk(resp, RESP_SLVERR, "unmapped write");
    axi_read(8'h18, rd_val, resp);
    chk(resp, RESP_SLVERR, "unmapped read response");
    chk(rd_val, 32'h0, "unmapped read data");
    $display("test interrupt done");
  endtask : t_irq

  initial begin
    sys_rst = 1'b1; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0;
    rready = 1'b0; awaddr = '0; araddr = '0; wdata = '0; wstrb = 4'hf;
    drv = 4'h0; ack = 4'h0; n_errors = 0; samples_checked = 0;
    do_reset();
    t_reset();
    t_poll();
    t_request();
    t_nmi();
    t_output();
    t_irq();
    reg_wr(OFS_CTRL_B0, B_DIR | B_DOUT | B_POL);
    @(posedge clk);
    drv <= 4'h0;
    do_reset();
    t_reset();
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
